// >>> include/pcic_pkg.sv
package pcic_pkg;

   // program space
   localparam int          PC_W          = 13;
   localparam int          PAGE_AW       = 10;
   localparam int          PAGES         = 6;
   localparam int          PS_W          = 3;
   localparam logic [12:0] RESET_VECTOR  = 13'h0000;
   localparam logic [12:0] INT_VECTOR    = 13'h0001;
   localparam logic [12:0] PC_STEP       = 13'h0001;
   localparam int          STACK_DEPTH   = 8;

   // data space
   localparam int          REG_AW        = 6;
   localparam int          MEM_AW        = 8;
   localparam int          BANK_W        = 2;
   localparam logic [5:0]  IND_ADDR      = 6'h00;
   localparam logic [5:0]  STATUS_ADDR   = 6'h03;
   localparam logic [5:0]  RAMSEL_ADDR   = 6'h04;
   localparam logic [5:0]  COMMON_TOP    = 6'h1f;

   // field positions and reset values
   localparam int          PS_LSB        = 5;
   localparam int          BANK_LSB      = 6;
   localparam logic [7:0]  STATUS_RST    = 8'h18;
   localparam logic [7:0]  RAMSEL_RST    = 8'h00;
   localparam logic [7:0]  ACC_RST       = 8'h00;

   // interrupt source bit positions
   localparam int          NUM_SRC       = 6;
   localparam int          SRC_TIMER     = 0;
   localparam int          SRC_PIN       = 1;
   localparam int          SRC_EP0       = 2;
   localparam int          SRC_SUSPEND   = 3;
   localparam int          SRC_BUS_RESET = 4;
   localparam int          SRC_RESUME    = 5;

   // timing
   localparam int          CLKS_PER_INSN = 2;

   typedef enum logic [1:0] {
      PH_FETCH = 2'b01,
      PH_EXEC  = 2'b10
   } pcic_phase_t;

endpackage : pcic_pkg

// >>> include/pcic_stack_if.sv
`timescale 1ns/1ps
interface pcic_stack_if #(
   parameter int W = 13
);
   logic         push;
   logic         pop;
   logic [W-1:0] push_data;
   logic [W-1:0] top_data;

   modport owner (output push, output pop, output push_data, input top_data);
   modport store (input push, input pop, input push_data, output top_data);
endinterface : pcic_stack_if

// >>> hw/pcic_stack.sv
`timescale 1ns/1ps
module pcic_stack #(
   parameter int DEPTH = pcic_pkg::STACK_DEPTH,
   parameter int W     = pcic_pkg::PC_W
) (
   input  wire logic   clk_i,
   input  wire logic   rstn_i,
   pcic_stack_if.store stk
);
   localparam int PW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << PW) != DEPTH)
      begin : g_bad_depth
         $error("pcic_stack: DEPTH must be a power of two, at least 2");
      end
   endgenerate

   logic [W-1:0]  mem [DEPTH];
   logic [PW-1:0] sp;

   // circular: a ninth push silently overwrites the oldest entry
   wire [PW-1:0] top_idx = sp - PW'(1);

   assign stk.top_data = mem[top_idx];

   always_ff @(posedge clk_i)
   begin
      if (!rstn_i)
         sp <= '0;
      else if (stk.push)
         sp <= sp + PW'(1);
      else if (stk.pop)
         sp <= top_idx;
   end

   always_ff @(posedge clk_i)
   begin
      if (stk.push)
         mem[sp] <= stk.push_data;
   end
endmodule : pcic_stack

// >>> hw/pcic_core.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Every reset clears the 13-bit instruction address so fetch starts at address zero.
// - Program space is six pages of 1K words, addressed by page bits plus in-page address.
// - All six interrupt sources enter through the one vector address 0x0001.
// - Interrupt entry copies accumulator, status and RAM-select into shadow storage.
// - Interrupt entry then clears the three page bits and fetches from the vector.
// - Return-from-interrupt restores the three registers, pops the stack and re-enables.
// - An 8-level return stack serves both calls and interrupt entry.
// - The indirect location holds nothing; access goes to the address in RAM-select.
// - Control registers are reached only by the two control read and write instructions.
// - One instruction cycle takes exactly two core clocks.
// - Page bits are status bits 7 to 5 and choose the page for jumps and calls.
// - RAM-select low six bits address up to 0x3F, the top two pick one of four banks.
module pcic_core #(
   parameter int PAGES       = pcic_pkg::PAGES,
   parameter int STACK_DEPTH = pcic_pkg::STACK_DEPTH
) (
   input  wire logic [pcic_pkg::PAGE_AW-1:0] JUMP_TARGET_I,
   input  wire logic [pcic_pkg::REG_AW-1:0]  DM_ADDR_I,
   input  wire logic [7:0]                   DM_WDATA_I,
   input  wire logic [7:0]                   CTRL_WDATA_I,
   input  wire logic [7:0]                   ACC_I,
   input  wire logic [pcic_pkg::NUM_SRC-1:0] INT_REQ_I,
   input  wire logic [3:0]                   CTRL_ADDR_I,
   input  wire logic                         CLK_I,
   input  wire logic                         RSTN_I,
   input  wire logic                         JUMP_I,
   input  wire logic                         CALL_I,
   input  wire logic                         RET_I,
   input  wire logic                         RETURN_FROM_INTERRUPT_INSTR_I,
   input  wire logic                         DM_RD_I,
   input  wire logic                         DM_WR_I,
   input  wire logic                         CTRL_RD_I,
   input  wire logic                         CTRL_WR_I,
   input  wire logic                         INT_ENABLE_I,
   input  wire logic                         INT_DISABLE_I,
   output logic [pcic_pkg::PC_W-1:0]         PC_O,
   output logic                              EXEC_O,
   output logic [pcic_pkg::MEM_AW-1:0]       MEM_ADDR_O,
   output logic [7:0]                        MEM_WDATA_O,
   output logic                              MEM_WE_O,
   output logic                              MEM_RE_O,
   output logic [3:0]                        CTRL_ADDR_O,
   output logic [7:0]                        CTRL_WDATA_O,
   output logic                              CTRL_WE_O,
   output logic                              CTRL_RE_O,
   output logic [7:0]                        LOCAL_RDATA_O,
   output logic                              LOCAL_RD_O,
   output logic [7:0]                        STATUS_O,
   output logic [7:0]                        RAMSEL_O,
   output logic [7:0]                        ACC_RESTORE_O,
   output logic                              ACC_LOAD_O,
   output logic                              INT_TAKEN_O,
   output logic [pcic_pkg::NUM_SRC-1:0]      INT_SRC_O,
   output logic                              INT_ENABLED_O
);
   generate
      if (PAGES < 1 || PAGES > (1 << pcic_pkg::PS_W))
      begin : g_bad_pages
         $error("pcic_core: PAGES must lie between 1 and 8");
      end
   endgenerate

   // resolve an operand register number to a physical data address
   function automatic logic [pcic_pkg::MEM_AW-1:0] resolve_addr(
      input logic [pcic_pkg::REG_AW-1:0] reg_addr,
      input logic [7:0]                  ram_sel
   );
      logic [pcic_pkg::REG_AW-1:0] low;
      logic [pcic_pkg::BANK_W-1:0] bank;
      low  = (reg_addr == pcic_pkg::IND_ADDR) ? ram_sel[pcic_pkg::REG_AW-1:0] : reg_addr;
      bank = (low > pcic_pkg::COMMON_TOP) ? ram_sel[pcic_pkg::BANK_LSB +: pcic_pkg::BANK_W]
                                          : '0;
      resolve_addr = {bank, low};
   endfunction : resolve_addr

   pcic_pkg::pcic_phase_t phase;

   logic [7:0] shadow_acc;
   logic [7:0] shadow_status;
   logic [7:0] shadow_ramsel;

   pcic_stack_if #(.W(pcic_pkg::PC_W)) stk ();

   pcic_stack #(
      .DEPTH (STACK_DEPTH),
      .W     (pcic_pkg::PC_W)
   ) u_stack (
      .clk_i  (CLK_I),
      .rstn_i (RSTN_I),
      .stk    (stk)
   );

   // instructions are sampled only on the second clock of each cycle
   wire exec = (phase == pcic_pkg::PH_EXEC);

   wire flow     = JUMP_I | CALL_I | RET_I | RETURN_FROM_INTERRUPT_INSTR_I;
   // entry only between plain instructions so one push per cycle
   wire take_int = exec & INT_ENABLED_O & (|INT_REQ_I) & ~flow;
   wire do_return_from_interrupt_instr  = exec & RETURN_FROM_INTERRUPT_INSTR_I;
   wire do_pop   = exec & (RET_I | RETURN_FROM_INTERRUPT_INSTR_I);
   wire do_push  = exec & CALL_I | take_int;

   wire [pcic_pkg::MEM_AW-1:0] eff_addr = resolve_addr(DM_ADDR_I, RAMSEL_O);

   wire hit_null   = (eff_addr == {2'b00, pcic_pkg::IND_ADDR});
   wire hit_status = (eff_addr == {2'b00, pcic_pkg::STATUS_ADDR});
   wire hit_ramsel = (eff_addr == {2'b00, pcic_pkg::RAMSEL_ADDR});
   wire hit_local  = hit_null | hit_status | hit_ramsel;

   wire dm_wr = exec & DM_WR_I;
   wire dm_rd = exec & DM_RD_I;

   wire [7:0] wr_status = (dm_wr & hit_status) ? DM_WDATA_I : STATUS_O;
   wire [7:0] wr_ramsel = (dm_wr & hit_ramsel) ? DM_WDATA_I : RAMSEL_O;

   wire [7:0] local_rdata = hit_status ? STATUS_O : hit_ramsel ? RAMSEL_O : 8'h00;

   wire [pcic_pkg::PC_W-1:0] pc_seq = PC_O + pcic_pkg::PC_STEP;
   // page from status bits 7..5 joins the 1K in-page target
   wire [pcic_pkg::PC_W-1:0] pc_far =
      {STATUS_O[pcic_pkg::PS_LSB +: pcic_pkg::PS_W], JUMP_TARGET_I};

   wire [pcic_pkg::PC_W-1:0] next_pc =
      !exec              ? PC_O :
      (RET_I | RETURN_FROM_INTERRUPT_INSTR_I)   ? stk.top_data :
      (JUMP_I | CALL_I)  ? pc_far :
      take_int           ? pcic_pkg::INT_VECTOR :
                           pc_seq;

   assign stk.push      = do_push;
   assign stk.pop       = do_pop;
   assign stk.push_data = pc_seq;

   always_ff @(posedge CLK_I)
   begin
      if (!RSTN_I)
      begin
         phase <= pcic_pkg::PH_FETCH;
         PC_O  <= pcic_pkg::RESET_VECTOR;
      end
      else
      begin
         phase <= exec ? pcic_pkg::PH_FETCH : pcic_pkg::PH_EXEC;
         PC_O  <= next_pc;
      end
   end

   // one-hot exec bit, taken straight from the phase flop
   assign EXEC_O = phase[1];

   // status and RAM-select: return overrides datapath writes; interrupt entry keeps them but clears the page bits
   always_ff @(posedge CLK_I)
   begin
      if (!RSTN_I)
      begin
         STATUS_O <= pcic_pkg::STATUS_RST;
         RAMSEL_O <= pcic_pkg::RAMSEL_RST;
      end
      else if (do_return_from_interrupt_instr)
      begin
         STATUS_O <= shadow_status;
         RAMSEL_O <= shadow_ramsel;
      end
      else if (take_int)
      begin
         STATUS_O <= {{pcic_pkg::PS_W{1'b0}}, wr_status[pcic_pkg::PS_LSB-1:0]};
         RAMSEL_O <= wr_ramsel;
      end
      else
      begin
         STATUS_O <= wr_status;
         RAMSEL_O <= wr_ramsel;
      end
   end

   // single shadow set; valid only because nesting is held off
   always_ff @(posedge CLK_I)
   begin
      if (!RSTN_I)
      begin
         shadow_acc    <= pcic_pkg::ACC_RST;
         shadow_status <= pcic_pkg::STATUS_RST;
         shadow_ramsel <= pcic_pkg::RAMSEL_RST;
      end
      else if (take_int)
      begin
         shadow_acc    <= ACC_I;
         shadow_status <= wr_status;
         shadow_ramsel <= wr_ramsel;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RSTN_I)
         INT_ENABLED_O <= 1'b0;
      else if (do_return_from_interrupt_instr)
         INT_ENABLED_O <= 1'b1;
      else if (take_int | (exec & INT_DISABLE_I))
         INT_ENABLED_O <= 1'b0;
      else if (exec & INT_ENABLE_I)
         INT_ENABLED_O <= 1'b1;
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RSTN_I)
      begin
         INT_TAKEN_O   <= 1'b0;
         INT_SRC_O     <= '0;
         ACC_LOAD_O    <= 1'b0;
         ACC_RESTORE_O <= pcic_pkg::ACC_RST;
      end
      else
      begin
         INT_TAKEN_O   <= take_int;
         INT_SRC_O     <= take_int ? INT_REQ_I : INT_SRC_O;
         ACC_LOAD_O    <= do_return_from_interrupt_instr;
         ACC_RESTORE_O <= shadow_acc;
      end
   end

   // data path never raises control strobes and vice versa
   always_ff @(posedge CLK_I)
   begin
      if (!RSTN_I)
      begin
         MEM_ADDR_O    <= '0;
         MEM_WDATA_O   <= 8'h00;
         MEM_WE_O      <= 1'b0;
         MEM_RE_O      <= 1'b0;
         LOCAL_RD_O    <= 1'b0;
         LOCAL_RDATA_O <= 8'h00;
      end
      else
      begin
         MEM_ADDR_O    <= eff_addr;
         MEM_WDATA_O   <= DM_WDATA_I;
         MEM_WE_O      <= dm_wr & ~hit_local;
         MEM_RE_O      <= dm_rd & ~hit_local;
         LOCAL_RD_O    <= dm_rd & hit_local;
         LOCAL_RDATA_O <= local_rdata;
      end
   end

   always_ff @(posedge CLK_I)
   begin
      if (!RSTN_I)
      begin
         CTRL_ADDR_O  <= 4'h0;
         CTRL_WDATA_O <= 8'h00;
         CTRL_WE_O    <= 1'b0;
         CTRL_RE_O    <= 1'b0;
      end
      else
      begin
         CTRL_ADDR_O  <= CTRL_ADDR_I;
         CTRL_WDATA_O <= CTRL_WDATA_I;
         CTRL_WE_O    <= exec & CTRL_WR_I;
         CTRL_RE_O    <= exec & CTRL_RD_I;
      end
   end
endmodule : pcic_core

// >>> dv/pcic_core_asserts.sv
`timescale 1ns/1ps
module pcic_core_asserts (
   input wire logic        CLK_I,
   input wire logic        RSTN_I,
   input wire logic        JUMP_I,
   input wire logic        CALL_I,
   input wire logic        RET_I,
   input wire logic        RETURN_FROM_INTERRUPT_INSTR_I,
   input wire logic        DM_WR_I,
   input wire logic        CTRL_WR_I,
   input wire logic [9:0]  JUMP_TARGET_I,
   input wire logic [5:0]  DM_ADDR_I,
   input wire logic [7:0]  DM_WDATA_I,
   input wire logic [5:0]  INT_REQ_I,
   input wire logic        EXEC_O,
   input wire logic [12:0] PC_O,
   input wire logic [7:0]  STATUS_O,
   input wire logic [7:0]  RAMSEL_O,
   input wire logic [7:0]  MEM_ADDR_O,
   input wire logic        MEM_WE_O,
   input wire logic        CTRL_WE_O,
   input wire logic        ACC_LOAD_O,
   input wire logic        INT_TAKEN_O,
   input wire logic        INT_ENABLED_O
);
   wire logic [2:0] page_bits = STATUS_O[7:5];
   wire logic [5:0] sel_low   = RAMSEL_O[5:0];
   wire logic       no_flow   = !(JUMP_I || CALL_I || RET_I || RETURN_FROM_INTERRUPT_INSTR_I);
   default clocking cb @(posedge CLK_I);
   endclocking
   default disable iff (!RSTN_I);
   sequence int_accept;
      EXEC_O && INT_ENABLED_O && (INT_REQ_I != 6'h00) && no_flow;
   endsequence
   sequence ind_write;
      EXEC_O && DM_WR_I && (DM_ADDR_I == pcic_pkg::IND_ADDR) && (sel_low != 6'h00)
         && (sel_low != 6'h03) && (sel_low != 6'h04);
   endsequence
   AST_RESET_PC: assert property ($rose(RSTN_I) |-> (PC_O == 13'h0000) && !EXEC_O)
      else $error("pc not at reset vector after reset");
   AST_INSN_PHASE: assert property (EXEC_O |=> !EXEC_O ##1 EXEC_O)
      else $error("instruction cycle not two clocks");
   AST_INT_ENTRY: assert property (int_accept |=> (PC_O == pcic_pkg::INT_VECTOR)
      && INT_TAKEN_O && (page_bits == 3'h0) && !INT_ENABLED_O)
      else $error("interrupt entry wrong");
   AST_HOLD_OFF: assert property (EXEC_O && !INT_ENABLED_O |=> !INT_TAKEN_O)
      else $error("interrupt taken while disabled");
   AST_RETURN_FROM_INTERRUPT_INSTR: assert property (EXEC_O && RETURN_FROM_INTERRUPT_INSTR_I |=> INT_ENABLED_O && ACC_LOAD_O)
      else $error("return did not re-enable or restore");
   AST_JUMP_PAGE: assert property (EXEC_O && JUMP_I && !RET_I && !RETURN_FROM_INTERRUPT_INSTR_I |=>
      PC_O == {$past(page_bits), $past(JUMP_TARGET_I)})
      else $error("jump address not page plus target");
   AST_RAMSEL_WR: assert property (EXEC_O && DM_WR_I && (DM_ADDR_I == 6'h04) && !RETURN_FROM_INTERRUPT_INSTR_I
      |=> (RAMSEL_O == $past(DM_WDATA_I)) && !MEM_WE_O)
      else $error("ram select write wrong");
   AST_IND_WR: assert property (ind_write |=> MEM_WE_O && MEM_ADDR_O[5:0] == $past(sel_low))
      else $error("indirect write not redirected");
   AST_CTRL_ONLY: assert property (EXEC_O && DM_WR_I && !CTRL_WR_I |=> !CTRL_WE_O)
      else $error("data write reached control register");
endmodule : pcic_core_asserts

// >>> dv/pcic_core_bench.sv
`timescale 1ns/1ps
module pcic_core_bench;
   logic        clk, rstn, ex, mwe, mre, cwe, cre, lre, al, tk, ien;
   logic [3:0]  fl, ca;
   logic [1:0]  dm, xo, yo;
   logic [9:0]  tgt;
   logic [5:0]  da, rq, srcs;
   logic [7:0]  dd, acc, ma, md, cd, lrd, st, rs, ar;
   logic [12:0] pc;
   int          n_mismatch = 0;
   int          n_tests = 0;
   int          cyc = 0;
   pcic_core u_pcic_core (
      .CLK_I(clk), .RSTN_I(rstn), .JUMP_TARGET_I(tgt), .DM_ADDR_I(da), .DM_WDATA_I(dd),
      .CTRL_WDATA_I(dd), .ACC_I(acc), .INT_REQ_I(rq), .CTRL_ADDR_I(da[3:0]), .JUMP_I(fl[0]),
      .CALL_I(fl[1]), .RET_I(fl[2]), .RETURN_FROM_INTERRUPT_INSTR_I(fl[3]), .DM_RD_I(dm[0]), .DM_WR_I(dm[1]),
      .CTRL_RD_I(yo[0]), .CTRL_WR_I(xo[0]), .INT_ENABLE_I(xo[1]), .INT_DISABLE_I(yo[1]),
      .PC_O(pc), .EXEC_O(ex), .MEM_ADDR_O(ma), .MEM_WDATA_O(md), .MEM_WE_O(mwe), .MEM_RE_O(mre),
      .CTRL_ADDR_O(ca), .CTRL_WDATA_O(cd), .CTRL_WE_O(cwe), .CTRL_RE_O(cre), .LOCAL_RDATA_O(lrd),
      .LOCAL_RD_O(lre), .STATUS_O(st), .RAMSEL_O(rs), .ACC_RESTORE_O(ar), .ACC_LOAD_O(al),
      .INT_TAKEN_O(tk), .INT_SRC_O(srcs), .INT_ENABLED_O(ien));
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic finish_test();
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // drive just before an execute edge, clear on it, return where outputs have settled
   task automatic issue(input logic [3:0] f, input logic [9:0] t, input logic [1:0] d,
                        input logic [5:0] a, input logic [7:0] v, input logic [1:0] x,
                        input logic [5:0] r, input logic [1:0] y = 2'b00);
      @(posedge clk);
      while (ex !== 1'b0)
         @(posedge clk);
      fl <= f;
      tgt <= t;
      dm <= d;
      da <= a;
      dd <= v;
      xo <= x;
      yo <= y;
      rq <= r;
      @(posedge clk);
      fl <= 4'h0;
      dm <= 2'b00;
      xo <= 2'b00;
      yo <= 2'b00;
      rq <= 6'h00;
      @(negedge clk);
   endtask : issue
   task automatic wr(input logic [5:0] a, input logic [7:0] v);
      issue(4'h0, 10'h000, 2'b10, a, v, 2'b00, 6'h00);
   endtask : wr
   task automatic t_page();
      for (int p = 0; p < pcic_pkg::PAGES; p++)
      begin
         wr(pcic_pkg::STATUS_ADDR, {3'(p), 5'h18});
         issue(4'h1, 10'h3ff - 10'(p), 2'b00, 6'h00, 8'h00, 2'b00, 6'h00);
         chk(32'(pc), 32'({3'(p), 10'h3ff - 10'(p)}));
      end
      $display("t_page done");
   endtask : t_page
   task automatic t_int();
      logic [12:0] ret;
      wr(pcic_pkg::STATUS_ADDR, 8'h18);
      issue(4'h1, 10'h040, 2'b00, 6'h00, 8'h00, 2'b10, 6'h00);
      wr(pcic_pkg::RAMSEL_ADDR, 8'h85);
      for (int s = 0; s < pcic_pkg::NUM_SRC; s++)
      begin
         wr(pcic_pkg::STATUS_ADDR, 8'h78);
         ret = pc + pcic_pkg::PC_STEP;
         issue(4'h0, 10'h000, 2'b00, 6'h00, 8'h00, 2'b00, 6'(1 << s));
         chk(32'(pc), 32'(pcic_pkg::INT_VECTOR));
         chk(32'({tk, ien, srcs, st}), 32'({2'b10, 6'(1 << s), 8'h18}));
         // handler keeps requests raised; single shadow copy must survive
         issue(4'h0, 10'h000, 2'b00, 6'h00, 8'h00, 2'b00, 6'h3f);
         chk(32'({tk, pc}), 32'h0002);
         wr(pcic_pkg::RAMSEL_ADDR, 8'h22);
         wr(pcic_pkg::STATUS_ADDR, 8'hb8);
         // disable strobe alongside return: the return still re-enables
         issue(4'h8, 10'h000, 2'b00, 6'h00, 8'h00, 2'b00, 6'h00, 2'b10);
         chk(32'(pc), 32'(ret));
         chk(32'({al, ien, ar, st, rs}), 32'h35a7885);
      end
      $display("t_int done");
   endtask : t_int
   task automatic t_stack();
      logic [12:0] q[$];
      for (int i = 0; i < pcic_pkg::STACK_DEPTH; i++)
      begin
         q.push_back(pc + pcic_pkg::PC_STEP);
         issue(4'h2, 10'(i * 64), 2'b00, 6'h00, 8'h00, 2'b00, 6'h00);
      end
      for (int i = 0; i < pcic_pkg::STACK_DEPTH; i++)
      begin
         issue(4'h4, 10'h000, 2'b00, 6'h00, 8'h00, 2'b00, 6'h00);
         chk(32'(pc), 32'(q.pop_back()));
      end
      $display("t_stack done");
   endtask : t_stack
   task automatic t_ind();
      logic [7:0] sel[3] = '{8'hbc, 8'h8c, 8'h40};
      logic [7:0] adr[3] = '{8'hbc, 8'h0c, 8'h00};
      for (int i = 0; i < 3; i++)
      begin
         wr(pcic_pkg::RAMSEL_ADDR, sel[i]);
         wr(pcic_pkg::IND_ADDR, 8'h77);
         chk(32'(mwe), 32'(i < 2));
         if (i < 2)
            chk(32'({ma, md}), 32'({adr[i], 8'h77}));
      end
      issue(4'h0, 10'h000, 2'b01, pcic_pkg::IND_ADDR, 8'h00, 2'b00, 6'h00);
      chk(32'({lre, lrd, mre}), 32'h200);
      $display("t_ind done");
   endtask : t_ind
   task automatic t_ctrl();
      issue(4'h0, 10'h000, 2'b00, 6'h0a, 8'h3c, 2'b01, 6'h00);
      chk(32'({cwe, ca, cd, mwe}), 32'h3478);
      wr(6'h0a, 8'h3c);
      chk(32'({cwe, mwe, ma}), 32'h10a);
      wr(6'h25, 8'h3c);
      chk(32'(ma), 32'h65);
      issue(4'h0, 10'h000, 2'b00, 6'h05, 8'h00, 2'b00, 6'h00, 2'b01);
      chk(32'({cre, ca, mre, lre}), 32'h54);
      issue(4'h0, 10'h000, 2'b00, 6'h00, 8'h00, 2'b00, 6'h00, 2'b10);
      issue(4'h0, 10'h000, 2'b00, 6'h00, 8'h00, 2'b00, 6'h01);
      chk(32'({tk, ien}), 32'h0);
      $display("t_ctrl done");
   endtask : t_ctrl
   initial
   begin
      rstn = 1'b0;
      fl = 4'h0;
      dm = 2'b00;
      xo = 2'b00;
      yo = 2'b00;
      tgt = 10'h000;
      da = 6'h00;
      dd = 8'h00;
      rq = 6'h00;
      acc = 8'h5a;
      repeat (8) @(posedge clk);
      chk(32'({pc, st, rs, ien}), 32'h00003000);
      rstn <= 1'b1;
      t_page();
      t_int();
      t_stack();
      t_ind();
      t_ctrl();
      finish_test();
   end
endmodule : pcic_core_bench
bind pcic_core pcic_core_asserts u_pcic_core_asserts (
   .CLK_I(CLK_I), .RSTN_I(RSTN_I), .JUMP_I(JUMP_I), .CALL_I(CALL_I), .RET_I(RET_I),
   .RETURN_FROM_INTERRUPT_INSTR_I(RETURN_FROM_INTERRUPT_INSTR_I), .DM_WR_I(DM_WR_I), .CTRL_WR_I(CTRL_WR_I), .JUMP_TARGET_I(JUMP_TARGET_I),
   .DM_ADDR_I(DM_ADDR_I), .DM_WDATA_I(DM_WDATA_I), .INT_REQ_I(INT_REQ_I), .EXEC_O(EXEC_O),
   .PC_O(PC_O), .STATUS_O(STATUS_O), .RAMSEL_O(RAMSEL_O), .MEM_ADDR_O(MEM_ADDR_O),
   .MEM_WE_O(MEM_WE_O), .CTRL_WE_O(CTRL_WE_O), .ACC_LOAD_O(ACC_LOAD_O),
   .INT_TAKEN_O(INT_TAKEN_O), .INT_ENABLED_O(INT_ENABLED_O));
